// *** ewec_pkg.sv ***
// Package for the edge wakeup event controller: register map, field layout, widths.
// Assumes one synchronous clock domain and a plain strobe register port.
// Overview of operation
// (RL1) The controller has 41 edge detector lines, each raising an interrupt or event and able to wake the system.
// (RL2) Each external line selects rising only, falling only, or both edges as its trigger.
// (RL3) Each line has its own mask so one line can be silenced without touching the others.
// (RL4) A pending register records, per line, that a configured edge was seen.
// (RL5) Internal lines come from wakeup-capable peripherals and their requests end Stop mode.
// (RL6) An external line catches a pulse shorter than one internal clock period.
// (RL7) There are 16 external lines, each fed from one of up to 136 general-purpose pins.
// (RL8) A pending bit stays set until software writes a one to clear it, removing the request.
package ewec_pkg;
    // ==========================================================
    // Sizes
    localparam int EWEC_LINES = 41;
    localparam int EWEC_EXT_LINES = 16;
    localparam int EWEC_PINS = 136;
    localparam int EWEC_PIN_SEL_W = 8;
    localparam int EWEC_ADDR_W = 8;
    localparam int EWEC_DATA_W = 32;
    localparam int EWEC_HI_W = EWEC_LINES - 32;

    // ==========================================================
    // Register offsets (byte addresses, one word each)
    localparam logic [7:0] EWEC_IMR_LO = 8'h00; // Interrupt mask, lines 0..31
    localparam logic [7:0] EWEC_IMR_HI = 8'h04; // Interrupt mask, lines 32..40
    localparam logic [7:0] EWEC_EMR_LO = 8'h08; // Event mask
    localparam logic [7:0] EWEC_EMR_HI = 8'h0c;
    localparam logic [7:0] EWEC_RISE_LO = 8'h10;
    localparam logic [7:0] EWEC_RISE_HI = 8'h14;
    localparam logic [7:0] EWEC_FALL_LO = 8'h18;
    localparam logic [7:0] EWEC_FALL_HI = 8'h1c;
    localparam logic [7:0] EWEC_PEND_LO = 8'h20;
    localparam logic [7:0] EWEC_PEND_HI = 8'h24;
    localparam logic [7:0] EWEC_IRQ_STAT = 8'h28; // Sticky wake/irq events, clear on read
    localparam logic [7:0] EWEC_IRQ_MASK = 8'h2c;
    localparam logic [7:0] EWEC_PINSEL0 = 8'h40; // 16 words, 8-bit pin index each

    // ==========================================================
    // Status bit positions
    localparam int EWEC_ST_PEND = 0; // A line became pending
    localparam int EWEC_ST_EVT = 1;  // An event pulse was issued
    localparam int EWEC_ST_W = 2;

    // ==========================================================
    // Reset values
    localparam logic [EWEC_LINES-1:0] EWEC_MASK_RST = '0;
    localparam logic [EWEC_PIN_SEL_W-1:0] EWEC_SEL_RST = 8'h00;

    typedef struct packed {
        logic [EWEC_ADDR_W-1:0] addr;
        logic [EWEC_DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } ewec_bus_t;
endpackage

// *** ewec_edge_catch.sv ***
// One external line's edge detector.
// Assumes the line input may toggle between clock edges; a latch-free capture is kept
// by sampling both the present level and a pulse flag that the source pin holds.
`timescale 1ns/100ps
`default_nettype none
module ewec_edge_catch
    import ewec_pkg::*;
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic pin_lvl,
    input wire logic pin_glitch,
    input wire logic rise_en,
    input wire logic fall_en,
    output logic hit
);
    typedef struct packed {
        logic last;
        logic hit;
    } ewec_ec_t;
    ewec_ec_t st_ff, nxt_st;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.last = pin_lvl;
        // Narrow pulse seen only through the glitch flag counts as both edges
        nxt_st.hit = (rise_en && (( pin_lvl && !st_ff.last) || pin_glitch)) ||
                     (fall_en && ((!pin_lvl &&  st_ff.last) || pin_glitch)); // RL2 RL6
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign hit = st_ff.hit;
endmodule
`default_nettype wire

// *** ewec_pin_mux.sv ***
// Routes one of the general-purpose pins onto an external line.
// Assumes pin inputs are synchronous to ref_clk.
`timescale 1ns/100ps
`default_nettype none
module ewec_pin_mux
    import ewec_pkg::*;
#(
    parameter int PINS = EWEC_PINS
) (
    input wire logic [PINS-1:0] pins,
    input wire logic [PINS-1:0] pin_glitch,
    input wire logic [EWEC_PIN_SEL_W-1:0] sel,
    output logic lvl,
    output logic glitch
);
    initial begin
        if (PINS < 1 || PINS > 256) $error("ewec_pin_mux: PINS out of range");
    end

    always_comb begin
        lvl = 1'b0;
        glitch = 1'b0;
        // Out-of-range select reads as an idle low line
        if (int'(sel) < PINS) begin
            lvl = pins[sel]; // RL7
            glitch = pin_glitch[sel];
        end
    end
endmodule
`default_nettype wire

// *** ewec_top.sv ***
// Edge wakeup event controller: 16 external and 25 internal edge lines with masks,
// pending flags, event pulses, wakeup request and a summary interrupt.
// Assumes a plain strobe register port and pins synchronous to ref_clk.
//
// Our own choices: the strobed register port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module ewec_top
    import ewec_pkg::*;
#(
    parameter int LINES = EWEC_LINES,
    parameter int EXT_LINES = EWEC_EXT_LINES,
    parameter int PINS = EWEC_PINS
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [EWEC_ADDR_W-1:0] reg_addr,
    input wire logic [EWEC_DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [EWEC_DATA_W-1:0] reg_rdata,
    input wire logic [PINS-1:0] gpio_in,
    input wire logic [PINS-1:0] gpio_glitch,
    input wire logic [LINES-EXT_LINES-1:0] periph_wake,
    output logic [LINES-1:0] line_irq,
    output logic [LINES-1:0] line_event,
    output logic stop_wakeup,
    output logic irq
);
    initial begin
        if (LINES != EWEC_LINES) $error("ewec_top: LINES must match register map");
        if (EXT_LINES < 1 || EXT_LINES > LINES || EXT_LINES > 16) $error("ewec_top: EXT_LINES out of range");
    end

    // ==========================================================
    // State
    typedef struct packed {
        logic [LINES-1:0] imask;
        logic [LINES-1:0] emask;
        logic [LINES-1:0] rise;
        logic [LINES-1:0] fall;
        logic [LINES-1:0] pend;
        logic [LINES-1:0] evt;
        logic [LINES-LINES+LINES-EXT_LINES-1:0] int_last;
        logic [EXT_LINES-1:0][EWEC_PIN_SEL_W-1:0] sel;
        logic [EWEC_ST_W-1:0] stat;
        logic [EWEC_ST_W-1:0] smask;
        logic [EWEC_DATA_W-1:0] rdata;
        logic wake;
    } ewec_st_t;
    ewec_st_t st_ff, nxt_st;

    ewec_bus_t bus;
    assign bus = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

    function automatic logic hit_addr(input logic [EWEC_ADDR_W-1:0] a, input logic [7:0] off);
        hit_addr = (a == off);
    endfunction

    // ==========================================================
    // External line capture
    logic [LINES-1:0] trig;
    genvar g;
    generate
        for (g = 0; g < EXT_LINES; g++) begin : g_ext
            logic lvl, gl;
            ewec_pin_mux #(.PINS(PINS)) u_mux (
                .pins(gpio_in),
                .pin_glitch(gpio_glitch),
                .sel(st_ff.sel[g]),
                .lvl(lvl),
                .glitch(gl)
            );
            ewec_edge_catch u_edge (
                .ref_clk(ref_clk),
                .sys_rst(sys_rst),
                .pin_lvl(lvl),
                .pin_glitch(gl),
                .rise_en(st_ff.rise[g]),
                .fall_en(st_ff.fall[g]),
                .hit(trig[g])
            ); // RL1 RL6 RL7
        end
    endgenerate

    // Internal lines: peripheral wake requests, edge detected here.
    // Continuous per-bit drivers, since the lower bits of trig come from instance ports.
    generate
        for (g = EXT_LINES; g < LINES; g++) begin : g_int
            assign trig[g] = (st_ff.rise[g] && periph_wake[g-EXT_LINES] && !st_ff.int_last[g-EXT_LINES]) ||
                             (st_ff.fall[g] && !periph_wake[g-EXT_LINES] && st_ff.int_last[g-EXT_LINES]); // RL5 RL2
        end
    endgenerate

    // ==========================================================
    // Register and line logic
    logic [LINES-1:0] wr_lo, wr_hi;
    logic [LINES-1:0] pclr;
    logic [LINES-1:0] new_pend;
    logic [EWEC_ST_W-1:0] st_set;

    always_comb begin
        wr_lo = {{EWEC_HI_W{1'b0}}, bus.wdata};
        wr_hi = {bus.wdata[EWEC_HI_W-1:0], 32'h0000_0000};
        nxt_st = st_ff;
        nxt_st.int_last = periph_wake;
        pclr = '0;
        if (bus.wr) begin
            if (hit_addr(bus.addr, EWEC_IMR_LO)) nxt_st.imask[31:0] = bus.wdata;
            if (hit_addr(bus.addr, EWEC_IMR_HI)) nxt_st.imask[LINES-1:32] = bus.wdata[EWEC_HI_W-1:0];
            if (hit_addr(bus.addr, EWEC_EMR_LO)) nxt_st.emask[31:0] = bus.wdata;
            if (hit_addr(bus.addr, EWEC_EMR_HI)) nxt_st.emask[LINES-1:32] = bus.wdata[EWEC_HI_W-1:0];
            if (hit_addr(bus.addr, EWEC_RISE_LO)) nxt_st.rise[31:0] = bus.wdata;
            if (hit_addr(bus.addr, EWEC_RISE_HI)) nxt_st.rise[LINES-1:32] = bus.wdata[EWEC_HI_W-1:0];
            if (hit_addr(bus.addr, EWEC_FALL_LO)) nxt_st.fall[31:0] = bus.wdata;
            if (hit_addr(bus.addr, EWEC_FALL_HI)) nxt_st.fall[LINES-1:32] = bus.wdata[EWEC_HI_W-1:0];
            if (hit_addr(bus.addr, EWEC_PEND_LO)) pclr = wr_lo; // RL8
            if (hit_addr(bus.addr, EWEC_PEND_HI)) pclr = wr_hi; // RL8
            if (hit_addr(bus.addr, EWEC_IRQ_MASK)) nxt_st.smask = bus.wdata[EWEC_ST_W-1:0];
            for (int i = 0; i < EXT_LINES; i++) begin
                if (hit_addr(bus.addr, EWEC_PINSEL0 + 8'(4 * i))) nxt_st.sel[i] = bus.wdata[EWEC_PIN_SEL_W-1:0];
            end
        end
        // Masked lines never set pending; set beats a same-cycle clear
        new_pend = trig & st_ff.imask; // RL3
        nxt_st.pend = (st_ff.pend & ~pclr) | new_pend; // RL4 RL8
        nxt_st.evt = trig & st_ff.emask; // RL3
        nxt_st.wake = |(nxt_st.pend) || |(trig & st_ff.emask); // RL1 RL5
        st_set = '0;
        st_set[EWEC_ST_PEND] = |new_pend;
        st_set[EWEC_ST_EVT] = |(trig & st_ff.emask);
        nxt_st.rdata = '0;
        if (bus.rd) begin
            unique case (1'b1)
                hit_addr(bus.addr, EWEC_IMR_LO): nxt_st.rdata = st_ff.imask[31:0];
                hit_addr(bus.addr, EWEC_IMR_HI): nxt_st.rdata = 32'(st_ff.imask[LINES-1:32]);
                hit_addr(bus.addr, EWEC_EMR_LO): nxt_st.rdata = st_ff.emask[31:0];
                hit_addr(bus.addr, EWEC_EMR_HI): nxt_st.rdata = 32'(st_ff.emask[LINES-1:32]);
                hit_addr(bus.addr, EWEC_RISE_LO): nxt_st.rdata = st_ff.rise[31:0];
                hit_addr(bus.addr, EWEC_RISE_HI): nxt_st.rdata = 32'(st_ff.rise[LINES-1:32]);
                hit_addr(bus.addr, EWEC_FALL_LO): nxt_st.rdata = st_ff.fall[31:0];
                hit_addr(bus.addr, EWEC_FALL_HI): nxt_st.rdata = 32'(st_ff.fall[LINES-1:32]);
                hit_addr(bus.addr, EWEC_PEND_LO): nxt_st.rdata = st_ff.pend[31:0];
                hit_addr(bus.addr, EWEC_PEND_HI): nxt_st.rdata = 32'(st_ff.pend[LINES-1:32]);
                hit_addr(bus.addr, EWEC_IRQ_STAT): nxt_st.rdata = 32'(st_ff.stat);
                hit_addr(bus.addr, EWEC_IRQ_MASK): nxt_st.rdata = 32'(st_ff.smask);
                default: begin
                    for (int i = 0; i < EXT_LINES; i++) begin
                        if (hit_addr(bus.addr, EWEC_PINSEL0 + 8'(4 * i))) nxt_st.rdata = 32'(st_ff.sel[i]);
                    end
                end
            endcase
        end
        // Read clears the sticky status, but a new event in the same cycle survives
        if (bus.rd && hit_addr(bus.addr, EWEC_IRQ_STAT)) begin
            nxt_st.stat = st_set;
        end else begin
            nxt_st.stat = st_ff.stat | st_set;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign reg_rdata = st_ff.rdata;
    assign line_irq = st_ff.pend; // RL4
    assign line_event = st_ff.evt;
    assign stop_wakeup = st_ff.wake; // RL1
    assign irq = |(st_ff.stat & st_ff.smask);
endmodule
`default_nettype wire

// *** ewec_monitor.sv ***
// Port checker for the edge wakeup event controller.
// Assumes ewec_pkg is compiled first; bound into ewec_top below.
`timescale 1ns/100ps
`default_nettype none
module ewec_chk
    import ewec_pkg::*;
#(
    parameter int LINES = EWEC_LINES,
    parameter int EXT_LINES = EWEC_EXT_LINES,
    parameter int PINS = EWEC_PINS
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [EWEC_ADDR_W-1:0] reg_addr,
    input wire logic [EWEC_DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [EWEC_DATA_W-1:0] reg_rdata,
    input wire logic [PINS-1:0] gpio_in,
    input wire logic [PINS-1:0] gpio_glitch,
    input wire logic [LINES-EXT_LINES-1:0] periph_wake,
    input wire logic [LINES-1:0] line_irq,
    input wire logic [LINES-1:0] line_event,
    input wire logic stop_wakeup,
    input wire logic irq
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    // ==========================================
    // Register port
    AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == '0)
        else $error("read data not zero outside a read");
    AST_PEND_READ: assert property (reg_rd && reg_addr == EWEC_PEND_LO |=> reg_rdata == $past(line_irq[31:0]))
        else $error("pending read differs from line_irq");
    AST_HOLE_READ: assert property (reg_rd && reg_addr == 8'h30 |=> reg_rdata == '0)
        else $error("unmapped read not zero");
    // ==========================================
    // Pending flags
    AST_STICKY: assert property (!(reg_wr && reg_addr == EWEC_PEND_LO)
        |=> (line_irq[31:0] & $past(line_irq[31:0])) == $past(line_irq[31:0]))
        else $error("pending bit dropped without a clear");
    AST_PEND_CLR: assert property (reg_wr && reg_addr == EWEC_PEND_HI && $stable(periph_wake)
        |=> (line_irq[40:32] & $past(reg_wdata[8:0])) == '0)
        else $error("pending bit survived a clear");
    AST_INT_CAUSE: assert property ((line_irq[40:16] & ~$past(line_irq[40:16])
        & ~($past(periph_wake) ^ $past(periph_wake, 2))) == '0)
        else $error("internal pending without a line edge");
    AST_EXT_CAUSE: assert property (|(line_irq[15:0] & ~$past(line_irq[15:0]))
        |-> $past(gpio_in, 2) != $past(gpio_in, 3) || |($past(gpio_glitch) | $past(gpio_glitch, 2)))
        else $error("external pending without a pin edge");
    AST_WAKE: assert property (|line_irq |-> ##[0:1] stop_wakeup)
        else $error("no wakeup while a line is pending");
    cover property ($rose(irq));
    cover property ($rose(|line_event));
    cover property ($rose(|line_irq[40:16]));
endmodule
bind ewec_top ewec_chk #(.LINES(LINES), .EXT_LINES(EXT_LINES), .PINS(PINS)) u_chk (.ref_clk, .sys_rst,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .gpio_in, .gpio_glitch, .periph_wake,
    .line_irq, .line_event, .stop_wakeup, .irq);
`default_nettype wire

// *** ewec_far.sv ***
// Pin and peripheral side model: drives pin levels, narrow-pulse flags, wake lines.
// Assumes the bench calls its tasks; all changes land just after a rising edge.
`timescale 1ns/100ps
`default_nettype none
module ewec_far
    import ewec_pkg::*;
(
    input wire logic ref_clk,
    output logic [EWEC_PINS-1:0] gpio_in,
    output logic [EWEC_PINS-1:0] gpio_glitch,
    output logic [EWEC_LINES-EWEC_EXT_LINES-1:0] periph_wake
);
    initial begin
        gpio_in = '0;
        gpio_glitch = '0;
        periph_wake = '0;
    end
    task automatic pin(input int p, input logic v);
        @(posedge ref_clk);
        gpio_in[p] <= v;
    endtask
    // Level never moves: only the pulse flag tells of the short pulse
    task automatic glitch(input int p);
        @(posedge ref_clk);
        gpio_glitch[p] <= 1'b1;
        @(posedge ref_clk);
        gpio_glitch[p] <= 1'b0;
    endtask
    task automatic wake(input int j, input logic v);
        @(posedge ref_clk);
        periph_wake[j] <= v;
    endtask
endmodule
`default_nettype wire

// *** ewec_top_tb.sv ***
// Self-checking bench for ewec_top with a pin/peripheral model.
// Assumes ewec_pkg, ewec_far and the bound checker are compiled before it.
`timescale 1ns/100ps
`default_nettype none
module ewec_top_tb
    import ewec_pkg::*;
;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] reg_addr = '0;
    logic [31:0] reg_wdata = '0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic rd_d = 1'b0;
    logic [40:0] e;
    logic [31:0] expq[$];
    wire logic [31:0] reg_rdata;
    wire logic [135:0] gpio_in, gpio_glitch;
    wire logic [24:0] periph_wake;
    wire logic [40:0] line_irq, line_event;
    wire logic stop_wakeup, irq;
    int miscompares = 0;
    int total_checks = 0;
    int cyc = 0;
    int ln, pin, j, m, n;
    always #25 ref_clk = ~ref_clk;
    ewec_top u_dut (.ref_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .gpio_in, .gpio_glitch, .periph_wake, .line_irq, .line_event, .stop_wakeup, .irq);
    ewec_far u_far (.ref_clk, .gpio_in, .gpio_glitch, .periph_wake);
    // ==========================================
    // Bus tasks and comparison
    task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic wr41(input logic [7:0] a, input logic [40:0] v);
        wr(a, v[31:0]);
        wr(a + 8'h04, {23'h0, v[40:32]});
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        expq.push_back(x);
        @(posedge ref_clk);
        reg_rd <= 1'b0;
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // Read data stands only in the cycle after the strobe
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (rd_d) check("reg_rdata", reg_rdata, expq.pop_front());
        rd_d <= reg_rd;
        if (cyc == 5000) begin
            miscompares++;
            tally_and_finish();
        end
    end
    // ==========================================
    // Tests
    initial begin
        void'($urandom(32'h2b3d));
        repeat (20) @(posedge ref_clk);
        sys_rst <= 1'b0;
        rd(EWEC_IMR_LO, 32'h0);
        wr(8'h30, 32'hffff_ffff);
        rd(8'h30, 32'h0);
        $display("test reset done");
        // Two lines share one pin; only the first is unmasked
        for (m = 1; m < 4; m++) begin
            ln = $urandom_range(14, 0);
            pin = $urandom_range(135, 0);
            wr(EWEC_PINSEL0 + 8'(4 * ln), 32'(pin));
            wr(EWEC_PINSEL0 + 8'(4 * ln + 4), 32'(pin));
            wr41(EWEC_IMR_LO, 41'(1) << ln);
            wr41(EWEC_RISE_LO, m[0] ? 41'(3) << ln : 41'(0));
            wr41(EWEC_FALL_LO, m[1] ? 41'(3) << ln : 41'(0));
            u_far.pin(pin, 1'b1);
            repeat (4) @(posedge ref_clk);
            rd(EWEC_PEND_LO, m[0] ? 32'(1) << ln : 32'h0);
            wr(EWEC_PEND_LO, 32'hffff_ffff);
            rd(EWEC_PEND_LO, 32'h0);
            u_far.pin(pin, 1'b0);
            repeat (4) @(posedge ref_clk);
            rd(EWEC_PEND_LO, m[1] ? 32'(1) << ln : 32'h0);
            wr(EWEC_PEND_LO, 32'hffff_ffff);
        end
        $display("test edges done");
        wr41(EWEC_RISE_LO, 41'(1) << ln);
        u_far.glitch(pin);
        repeat (4) @(posedge ref_clk);
        rd(EWEC_PEND_LO, 32'(1) << ln);
        #1 check("stop_wakeup", stop_wakeup, 1);
        wr(EWEC_PEND_LO, 32'hffff_ffff);
        $display("test glitch done");
        j = $urandom_range(24, 0);
        e = 41'(1) << (16 + j);
        wr41(EWEC_IMR_LO, e);
        wr41(EWEC_EMR_LO, e);
        wr41(EWEC_RISE_LO, e);
        rd(EWEC_IRQ_STAT, 32'h1);
        n = 0;
        u_far.wake(j, 1'b1);
        repeat (4) begin
            @(posedge ref_clk);
            #1 n += int'(line_event === e);
        end
        check("event pulses", n, 1);
        check("irq masked", irq, 0);
        wr(EWEC_IRQ_MASK, 32'h1);
        #1 check("irq", irq, 1);
        rd(EWEC_IRQ_STAT, 32'h3);
        #1 check("irq cleared", irq, 0);
        rd(EWEC_PEND_LO, e[31:0]);
        rd(EWEC_PEND_HI, {23'h0, e[40:32]});
        rd(EWEC_IMR_HI, {23'h0, e[40:32]});
        #1 check("line_irq", line_irq, e);
        wr41(EWEC_PEND_LO, '1);
        rd(EWEC_PEND_LO, 32'h0);
        $display("test internal done");
        // Falling edge on an upper-word internal line, cleared through the upper pending word
        j = $urandom_range(24, 16);
        e = 41'(1) << (16 + j);
        wr41(EWEC_IMR_LO, e);
        wr41(EWEC_RISE_LO, 41'h0);
        wr41(EWEC_FALL_LO, e);
        u_far.wake(j, 1'b1);
        repeat (2) @(posedge ref_clk);
        #1 check("rise ignored", line_irq, 41'h0);
        u_far.wake(j, 1'b0);
        repeat (2) @(posedge ref_clk);
        #1 check("fall pending", line_irq, e);
        wr(EWEC_PEND_HI, 32'h0000_01ff);
        rd(EWEC_PEND_HI, 32'h0);
        $display("test internal fall done");
        repeat (2) @(posedge ref_clk);
        tally_and_finish();
    end
endmodule
`default_nettype wire
